/* logic/rse_core.sv */
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// - Right rotate moves bits toward 0, carry into bit 7, bit 0 to carry.
// - Left rotate moves bits toward 7, carry into bit 0, bit 7 to carry.
// - Destination bit zero writes result to accumulator only.
// - Destination bit one writes result back to the file register.
// - Each rotate is one word and finishes in one instruction cycle.
// - Literal subtract gives literal minus accumulator into accumulator.
// - Register subtract gives file minus accumulator to chosen destination.
// - Subtract carry is one for no borrow, zero on borrow.
// - Sleep clears watchdog counter and its prescaler.
// - Sleep clears power-down flag and sets expiry flag.
// - Sleep halts the core with the oscillator stopped.
// - Sleep is recognised by its full fixed opcode.
module rse_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction stream, one word per instruction cycle
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  // File register space
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_addr,
  output logic [7:0] file_wdata,
  output logic file_we,
  // Watchdog tick from its own divider
  input wire logic wdog_tick,
  input wire logic wake,
  // Core state
  output logic [7:0] acc,
  output logic carry,
  output logic dcarry,
  output logic zero,
  output logic power_down_flag,
  output logic expiry_flag,
  output logic [7:0] watchdog_counter,
  output logic [7:0] wdog_prescaler,
  output logic osc_run,
  output logic halted
);
  rse_dec_if dec_bus ();
  rse_pkg::rse_state_type state;
  rse_pkg::rse_state_type next_state;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_dcarry;
  logic alu_zero;

  // Instruction decoding
  rse_decoder u_dec (
    .instr(instr),
    .instr_valid(instr_valid && (state == rse_pkg::RSE_RUN)),
    .dec(dec_bus)
  );

  // Datapath
  rse_alu u_alu (
    .op(dec_bus.op),
    .acc(acc),
    .file_data(file_rdata),
    .literal(dec_bus.literal),
    .carry_in(carry),
    .result(alu_result),
    .carry_out(alu_carry),
    .dcarry_out(alu_dcarry),
    .zero_out(alu_zero)
  );

  // Operation classes
  wire logic is_rot = (dec_bus.op == rse_pkg::RSE_OP_RRC) ||
                      (dec_bus.op == rse_pkg::RSE_OP_RLC);
  wire logic is_subf = dec_bus.op == rse_pkg::RSE_OP_SUBF;
  wire logic is_subl = dec_bus.op == rse_pkg::RSE_OP_SUBL;
  wire logic is_sub = is_subf || is_subl;
  wire logic is_sleep = dec_bus.op == rse_pkg::RSE_OP_SLEEP;
  wire logic has_dest = is_rot || is_subf;
  // Destination steering
  wire logic to_file = has_dest && dec_bus.dest_reg;
  wire logic to_acc = (has_dest && !dec_bus.dest_reg) || is_subl;
  wire logic [7:0] next_acc = to_acc ? alu_result : acc;
  wire logic next_carry = (is_rot || is_sub) ? alu_carry : carry;
  wire logic next_dcarry = is_sub ? alu_dcarry : dcarry;
  wire logic next_zero = is_sub ? alu_zero : zero;

  // Run and halt state
  always_comb begin
    next_state = state;
    case (state)
      rse_pkg::RSE_RUN: begin
        if (is_sleep) begin
          next_state = rse_pkg::RSE_HALT;
        end
      end
      rse_pkg::RSE_HALT: begin
        if (wake) begin
          next_state = rse_pkg::RSE_RUN;
        end
      end
      default: begin
        next_state = rse_pkg::RSE_RUN;
      end
    endcase
  end

  // File register address always follows the operand
  assign file_addr = dec_bus.addr;

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= rse_pkg::RSE_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Accumulator and arithmetic flags, one cycle per instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= rse_pkg::RESET_ACC;
      carry <= rse_pkg::RESET_CARRY;
      dcarry <= rse_pkg::RESET_DCARRY;
      zero <= rse_pkg::RESET_ZERO;
    end else begin
      acc <= next_acc;
      carry <= next_carry;
      dcarry <= next_dcarry;
      zero <= next_zero;
    end
  end

  // File write-back, one cycle strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      file_we <= 1'b0;
      file_wdata <= 8'h00;
    end else begin
      file_we <= to_file;
      file_wdata <= alu_result;
    end
  end

  // Power status flags
  always_ff @(posedge clk) begin
    if (reset) begin
      power_down_flag <= rse_pkg::RESET_POWER_DOWN;
      expiry_flag <= rse_pkg::RESET_EXPIRY;
    end else if (is_sleep) begin
      power_down_flag <= 1'b0;
      expiry_flag <= 1'b1;
    end
  end

  // Watchdog counter and prescaler
  always_ff @(posedge clk) begin
    if (reset || is_sleep) begin
      watchdog_counter <= rse_pkg::WDOG_CLEAR;
      wdog_prescaler <= rse_pkg::PRESC_CLEAR;
    end else if (wdog_tick) begin
      wdog_prescaler <= wdog_prescaler + 8'h01;
      if (wdog_prescaler == 8'hff) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // Oscillator control and halt indication
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_run <= 1'b1;
      halted <= 1'b0;
    end else begin
      osc_run <= (next_state == rse_pkg::RSE_RUN);
      halted <= (next_state == rse_pkg::RSE_HALT);
    end
  end
endmodule // rse_core

/* logic/rse_pkg.sv */
package rse_pkg;
  // Instruction word and operand widths
  localparam int unsigned WORD_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  // Opcode fields: bits 13:8 for byte ops, bits 13:9 for literal ops
  localparam logic [5:0] OP_ROT_RIGHT = 6'h0c;
  localparam logic [5:0] OP_ROT_LEFT = 6'h0d;
  localparam logic [5:0] OP_REG_SUB = 6'h02;
  localparam logic [4:0] OP_LIT_SUB = 5'h1e;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  // Field positions
  localparam int unsigned DEST_BIT = 7;
  // Status flag and accumulator values after reset
  localparam logic RESET_CARRY = 1'b0;
  localparam logic RESET_DCARRY = 1'b0;
  localparam logic RESET_ZERO = 1'b0;
  localparam logic RESET_POWER_DOWN = 1'b1;
  localparam logic RESET_EXPIRY = 1'b1;
  localparam logic [7:0] RESET_ACC = 8'h00;
  // Watchdog widths and reset values
  localparam int unsigned WDOG_W = 8;
  localparam int unsigned PRESC_W = 8;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_CLEAR = 8'h00;
  // Operation classes from the decoder
  typedef enum logic [2:0] {
    RSE_OP_NONE = 3'b000,
    RSE_OP_RRC = 3'b001,
    RSE_OP_RLC = 3'b010,
    RSE_OP_SUBL = 3'b011,
    RSE_OP_SUBF = 3'b100,
    RSE_OP_SLEEP = 3'b101
  } rse_op_type;
  // Core run state
  typedef enum logic [0:0] {
    RSE_RUN = 1'b0,
    RSE_HALT = 1'b1
  } rse_state_type;
endpackage

/* logic/rse_dec_if.sv */
`timescale 1ns/10ps
// Decoded instruction fields between decoder and execute core
interface rse_dec_if;
  rse_pkg::rse_op_type op;
  logic dest_reg;
  logic [7:0] literal;
  logic [6:0] addr;
  modport dec (output op, output dest_reg, output literal, output addr);
  modport exe (input op, input dest_reg, input literal, input addr);
endinterface

/* logic/rse_decoder.sv */
`timescale 1ns/10ps
module rse_decoder (
  // Instruction word
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  // Decoded fields
  rse_dec_if.dec dec
);
  // Opcode matches
  wire logic hit_rrc = instr[13:8] == rse_pkg::OP_ROT_RIGHT;
  wire logic hit_rlc = instr[13:8] == rse_pkg::OP_ROT_LEFT;
  wire logic hit_subf = instr[13:8] == rse_pkg::OP_REG_SUB;
  wire logic hit_subl = instr[13:9] == rse_pkg::OP_LIT_SUB;
  wire logic hit_sleep = instr == rse_pkg::OP_SLEEP;

  // Operation select
  assign dec.op = !instr_valid ? rse_pkg::RSE_OP_NONE :
                  hit_rrc ? rse_pkg::RSE_OP_RRC :
                  hit_rlc ? rse_pkg::RSE_OP_RLC :
                  hit_subf ? rse_pkg::RSE_OP_SUBF :
                  hit_subl ? rse_pkg::RSE_OP_SUBL :
                  hit_sleep ? rse_pkg::RSE_OP_SLEEP :
                  rse_pkg::RSE_OP_NONE;
  // Operand fields
  assign dec.dest_reg = instr[rse_pkg::DEST_BIT];
  assign dec.literal = instr[7:0];
  assign dec.addr = instr[6:0];
endmodule // rse_decoder

/* logic/rse_alu.sv */
`timescale 1ns/10ps
module rse_alu (
  // Operands
  input wire rse_pkg::rse_op_type op,
  input wire logic [7:0] acc,
  input wire logic [7:0] file_data,
  input wire logic [7:0] literal,
  input wire logic carry_in,
  // Results
  output logic [7:0] result,
  output logic carry_out,
  output logic dcarry_out,
  output logic zero_out
);
  // Subtraction as minuend plus inverted acc plus one
  wire logic [7:0] minuend = (op == rse_pkg::RSE_OP_SUBL) ? literal
                                                            : file_data;
  wire logic [8:0] diff = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
  wire logic [4:0] low_diff = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]}
                              + 5'h01;
  // Rotates through carry
  wire logic [7:0] rot_r = {carry_in, file_data[7:1]};
  wire logic [7:0] rot_l = {file_data[6:0], carry_in};
  wire logic is_sub = (op == rse_pkg::RSE_OP_SUBL) ||
                      (op == rse_pkg::RSE_OP_SUBF);

  // Result and flag select
  assign result = (op == rse_pkg::RSE_OP_RRC) ? rot_r :
                  (op == rse_pkg::RSE_OP_RLC) ? rot_l :
                  diff[7:0];
  assign carry_out = (op == rse_pkg::RSE_OP_RRC) ? file_data[0] :
                     (op == rse_pkg::RSE_OP_RLC) ? file_data[7] :
                     diff[8];
  assign dcarry_out = low_diff[4];
  assign zero_out = is_sub && (diff[7:0] == 8'h00);
endmodule // rse_alu

/* test/rse_core_checker.sv */
`timescale 1ns/10ps
module rse_core_checker (
  // Clock, reset and stimulus
  input wire logic clk, reset, instr_valid, wake,
  input wire logic [13:0] instr,
  input wire logic [7:0] file_rdata,
  // Observed core state
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_wdata, acc, watchdog_counter, wdog_prescaler,
  input wire logic file_we, carry, dcarry, zero, power_down_flag,
  input wire logic expiry_flag, osc_run, halted
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Which checked instruction is taken this edge
  wire take = instr_valid && !halted;
  wire take_rr = take && instr[13:8] == rse_pkg::OP_ROT_RIGHT;
  wire take_rl = take && instr[13:8] == rse_pkg::OP_ROT_LEFT;
  wire take_sf = take && instr[13:8] == rse_pkg::OP_REG_SUB;
  wire take_sl = take && instr[13:9] == rse_pkg::OP_LIT_SUB;
  wire take_sp = take && instr == rse_pkg::OP_SLEEP;
  a_rot_right_acc: assert property (
    take_rr && !instr[7] |=> !file_we && carry == $past(file_rdata[0]) &&
    acc == {$past(carry), $past(file_rdata[7:1])})
    else $error("right rotate into acc wrong");
  a_rot_left_back: assert property (
    take_rl && instr[7] |=> file_we && carry == $past(file_rdata[7]) &&
    file_wdata == {$past(file_rdata[6:0]), $past(carry)} && $stable(acc))
    else $error("left rotate write back wrong");
  a_rot_keep_flags: assert property (
    take_rr || take_rl |=> $stable(zero) && $stable(dcarry))
    else $error("rotate changed zero or digit carry");
  a_lit_sub_acc: assert property (
    take_sl |=> acc == 8'($past(instr[7:0]) - $past(acc)) &&
    carry == ($past(instr[7:0]) >= $past(acc)))
    else $error("literal subtract wrong");
  a_reg_sub_back: assert property (
    take_sf && instr[7] |=> file_we && $stable(acc) &&
    file_wdata == 8'($past(file_rdata) - $past(acc)) &&
    carry == ($past(file_rdata) >= $past(acc)))
    else $error("register subtract write back wrong");
  a_sleep_status: assert property (
    take_sp |=> !power_down_flag && expiry_flag)
    else $error("sleep status flags wrong");
  a_sleep_wdog_clear: assert property (
    take_sp |=> watchdog_counter == 8'h00 && wdog_prescaler == 8'h00)
    else $error("sleep left watchdog uncleared");
  a_sleep_halts: assert property (
    take_sp |=> halted && !osc_run ##1 (halted && !osc_run) || $past(wake))
    else $error("sleep did not halt");
  a_reg_sub_acc: assert property (
    take_sf && !instr[7] |=> !file_we &&
    acc == 8'($past(file_rdata) - $past(acc)))
    else $error("register subtract into acc wrong");
  a_sub_flags: assert property (
    take_sf || take_sl |=>
    zero == ($past(take_sl ? instr[7:0] : file_rdata) == $past(acc)) &&
    dcarry == ($past(take_sl ? instr[3:0] : file_rdata[3:0]) >=
    $past(acc[3:0])))
    else $error("subtract zero or digit carry wrong");
  a_halt_holds_acc: assert property (
    halted && !wake |=> $stable(acc) && !file_we)
    else $error("halted core changed state");
  a_addr_field: assert property (
    file_addr == instr[6:0])
    else $error("file address not taken from word");
endmodule // rse_core_checker

/* test/rotate_subtract_sleep_exec_bench.sv */
`timescale 1ns/10ps
module rotate_subtract_sleep_exec_bench;
  typedef struct packed {
    logic [13:0] i;
    logic [7:0] f, a;
    logic c, dc, z, we;
    logic [7:0] wd;
  } rse_row_type;
  logic clk = 0, reset = 1, instr_valid = 0, wdog_tick = 0, wake = 0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata = 8'h00, file_wdata, acc;
  logic [7:0] watchdog_counter, wdog_prescaler;
  logic [6:0] file_addr;
  logic file_we, carry, dcarry, zero, power_down_flag, expiry_flag;
  logic osc_run, halted;
  int n_mismatch = 0, total_checks = 0;
  // Ordered program: word, file data, then expected state afterwards
  rse_row_type rows [13] = '{
    '{14'h3c02, 8'h00, 8'h02, 1, 1, 0, 0, 8'h00},
    '{14'h0285, 8'h03, 8'h02, 1, 1, 0, 1, 8'h01},
    '{14'h0205, 8'h02, 8'h00, 1, 1, 1, 0, 8'h00},
    '{14'h0c85, 8'h01, 8'h00, 1, 1, 1, 1, 8'h80},
    '{14'h0000, 8'h55, 8'h00, 1, 1, 1, 0, 8'h00},
    '{14'h3d03, 8'h00, 8'h03, 1, 1, 0, 0, 8'h00},
    '{14'h3c02, 8'h00, 8'hff, 0, 0, 0, 0, 8'h00},
    '{14'h0c05, 8'he6, 8'h73, 0, 0, 0, 0, 8'h00},
    '{14'h0d05, 8'he6, 8'hcc, 1, 0, 0, 0, 8'h00},
    '{14'h0c85, 8'he6, 8'hcc, 0, 0, 0, 1, 8'hf3},
    '{14'h0d85, 8'h81, 8'hcc, 1, 0, 0, 1, 8'h02},
    '{14'h0285, 8'h10, 8'hcc, 0, 0, 0, 1, 8'h44},
    '{14'h0064, 8'h00, 8'hcc, 0, 0, 0, 0, 8'h00}};
  rse_core u_rse_core (.clk, .reset, .instr, .instr_valid, .file_rdata,
    .file_addr, .file_wdata, .file_we, .wdog_tick, .wake, .acc, .carry,
    .dcarry, .zero, .power_down_flag, .expiry_flag, .watchdog_counter,
    .wdog_prescaler, .osc_run, .halted);
  // Clock at 40 MHz
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #50000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    #1;
    chk("acc", acc, 8'h00);
    chk("flags", {carry, dcarry, zero, file_we, halted}, 5'h00);
    chk("status", {power_down_flag, expiry_flag, osc_run}, 3'h7);
    chk("wdog", watchdog_counter, 8'h00);
    for (int k = 0; k <= 13; k++) begin
      @(posedge clk);
      if (k < 13) begin
        instr <= rows[k].i;
        file_rdata <= rows[k].f;
        instr_valid <= 1;
      end else
        instr_valid <= 0;
      #1;
      if (k > 0) begin
        chk("acc", acc, rows[k-1].a);
        chk("carry", carry, rows[k-1].c);
        chk("dc_z", {dcarry, zero}, {rows[k-1].dc, rows[k-1].z});
        chk("we", file_we, rows[k-1].we);
        if (rows[k-1].we)
          chk("wdata", file_wdata, rows[k-1].wd);
      end
    end
    chk("still_awake", {power_down_flag, halted}, 2'h2);
    // Tick changes only at a rising edge, 260 ticks in all
    @(posedge clk);
    wdog_tick <= 1;
    repeat (260) @(posedge clk);
    wdog_tick <= 0;
    #1;
    chk("wdog", {watchdog_counter, wdog_prescaler}, 16'h0104);
    // Sleep with a tick in the same cycle
    @(posedge clk);
    wdog_tick <= 1;
    instr <= 14'h0063;
    instr_valid <= 1;
    @(posedge clk);
    wdog_tick <= 0;
    instr <= 14'h0c05;
    file_rdata <= 8'he6;
    #1;
    chk("sleep_wdog", {watchdog_counter, wdog_prescaler}, 16'h0000);
    chk("sleep_flags", {power_down_flag, expiry_flag}, 2'h1);
    chk("sleep_halt", {halted, osc_run}, 2'h2);
    repeat (3) @(posedge clk);
    #1;
    chk("halt_acc", acc, 8'hcc);
    @(posedge clk);
    wake <= 1;
    instr_valid <= 0;
    @(posedge clk);
    wake <= 0;
    @(posedge clk);
    #1;
    chk("woken", {halted, osc_run}, 2'h1);
    finish_test();
  end
endmodule // rotate_subtract_sleep_exec_bench
bind rse_core rse_core_checker u_rse_core_checker (.clk, .reset,
  .instr_valid, .wake, .instr, .file_rdata, .file_addr, .file_wdata, .acc,
  .watchdog_counter, .wdog_prescaler, .file_we, .carry, .dcarry, .zero,
  .power_down_flag, .expiry_flag, .osc_run, .halted);
